// ===== hdl/arith_defs.svh
// Register offsets, field positions and reset values of the arithmetic unit
`ifndef ARITH_DEFS_SVH
`define ARITH_DEFS_SVH
// ==========================================================
// Byte offsets
`define OFS_CONTROL 8'h00
`define OFS_FIRST 8'h04
`define OFS_SECOND 8'h08
`define OFS_RESULT 8'h0C
`define OFS_STATUS 8'h10
`define OFS_EVENT 8'h14
`define OFS_EVENT_CLEAR 8'h18
`define OFS_EVENT_ENABLE 8'h1C
// ==========================================================
// Field positions
`define CTRL_ACT_BIT 0
`define CTRL_OP_LSB 4
`define CTRL_OP_MSB 6
`define STATUS_STICKY_BIT 3
// ==========================================================
// Reset values and bus answers
`define RST_WORD 32'h0000_0000
`define RST_STATUS 6'h00
`define RST_EVENT 2'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== hdl/arith_pkg.sv
// Types shared by the arithmetic unit
`default_nettype none
package arith_pkg;
    typedef enum logic [2:0] {
        OP_SHORT_SUM = 3'h0,
        OP_LONG_SUM = 3'h1,
        OP_SHORT_DIFF = 3'h2,
        OP_LONG_DIFF = 3'h3,
        OP_SHORT_PRODUCT = 3'h4,
        OP_LONG_PRODUCT = 3'h5
    } opcode_t;

    // Bit 0 upward: condition lo, condition hi, range, sticky, contact, success
    typedef struct packed {
        logic success;
        logic contact_level_bit;
        logic sticky_error_flag;
        logic range_error_flag;
        logic condition_hi_bit;
        logic condition_lo_bit;
    } status_t;

    typedef struct packed {
        logic range_event;
        logic done_event;
    } event_t;
endpackage : arith_pkg
`default_nettype wire

// ===== hdl/integer_arith_unit.sv
// Signed integer add, subtract and multiply unit with AXI4-Lite registers
// How it works
// - Activated short sum adds the two 16-bit operands onto the result.
// - Short sum out of 16-bit range sets range and sticky flags, success low.
// - Activated long sum adds the two 32-bit operands onto the result.
// - Activated short difference subtracts second 16-bit operand from first.
// - Activated long difference subtracts second 32-bit operand from first.
// - Short product multiplies 16-bit operands, delivering the full 32-bit product.
// - Short product beyond 16-bit range flags error, product still delivered.
// - Activated long product multiplies the two 32-bit operands onto the result.
// - Any long result beyond 32-bit range flags error, success low.
// - Every executed operation writes the contact level bit to one.
// - Without activation nothing executes and success stays low.
// - In range: condition 00 zero, 01 negative, 10 positive; range clear.
// - Out of range: condition 10 positive, 01 negative overflow; both flags set.
`timescale 1ns/1ps
`include "arith_defs.svh"
`default_nettype none

module integer_arith_unit
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic success_output,
    output logic irq
);
    // ==========================================================
    // Write channel capture
    logic aw_held;
    logic w_held;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic do_write;
    logic wr_mapped;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_mapped = (wr_addr[31:8] == 24'h00_0000) && (wr_addr[1:0] == 2'h0)
        && (wr_addr[7:0] <= `OFS_EVENT_ENABLE);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            wr_addr <= `RST_WORD;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held <= 1'b0;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            wr_data <= `RST_WORD;
            wr_strb <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end
        else if (do_write)
            w_held <= 1'b0;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !do_write;
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !do_write;
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    // ==========================================================
    // Software registers
    logic [31:0] first_operand;
    logic [31:0] second_operand;
    arith_pkg::opcode_t opcode;
    logic activate;
    logic wr_hit_ctrl;
    logic [2:0] wr_op;
    assign wr_hit_ctrl = do_write && wr_mapped && wr_addr[7:0] == `OFS_CONTROL && wr_strb[0];
    assign wr_op = wr_data[`CTRL_OP_MSB:`CTRL_OP_LSB];
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            first_operand <= `RST_WORD;
            second_operand <= `RST_WORD;
        end
        else if (do_write && wr_mapped)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (wr_strb[i] && wr_addr[7:0] == `OFS_FIRST)
                    first_operand[8*i +: 8] <= wr_data[8*i +: 8];
                if (wr_strb[i] && wr_addr[7:0] == `OFS_SECOND)
                    second_operand[8*i +: 8] <= wr_data[8*i +: 8];
            end
        end
    end
    // Activate is a one-cycle pulse; unknown opcodes never start
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            activate <= 1'b0;
            opcode <= arith_pkg::OP_SHORT_SUM;
        end
        else if (wr_hit_ctrl)
        begin
            activate <= wr_data[`CTRL_ACT_BIT] && (wr_op <= 3'h5);
            if (wr_op <= 3'h5)
                opcode <= arith_pkg::opcode_t'(wr_op);
        end
        else
            activate <= 1'b0;
    end
    // ==========================================================
    // Datapath: exact result at 66 bits, then range check
    logic is_short;
    logic signed [65:0] op_a;
    logic signed [65:0] op_b;
    logic signed [65:0] exact;
    logic in_range;
    logic [31:0] next_result;
    assign is_short = opcode == arith_pkg::OP_SHORT_SUM
        || opcode == arith_pkg::OP_SHORT_DIFF || opcode == arith_pkg::OP_SHORT_PRODUCT;
    assign op_a = is_short ? {{50{first_operand[15]}}, first_operand[15:0]}
        : {{34{first_operand[31]}}, first_operand};
    assign op_b = is_short ? {{50{second_operand[15]}}, second_operand[15:0]}
        : {{34{second_operand[31]}}, second_operand};
    always_comb
    begin
        exact = '0;
        unique case (opcode)
            arith_pkg::OP_SHORT_SUM, arith_pkg::OP_LONG_SUM:
                exact = op_a + op_b;
            arith_pkg::OP_SHORT_DIFF, arith_pkg::OP_LONG_DIFF:
                exact = op_a - op_b;
            arith_pkg::OP_SHORT_PRODUCT, arith_pkg::OP_LONG_PRODUCT:
                exact = op_a * op_b;
        endcase
    end
    // Range: all bits above the sign bit match it
    assign in_range = is_short ? (&exact[65:15] || ~|exact[65:15])
        : (&exact[65:31] || ~|exact[65:31]);
    // Short product keeps all 32 bits; short sum and difference wrap to 16
    assign next_result = (is_short && opcode != arith_pkg::OP_SHORT_PRODUCT)
        ? {{16{exact[15]}}, exact[15:0]} : exact[31:0];
    // ==========================================================
    // Result, status word and success output
    logic [31:0] result;
    arith_pkg::status_t status;
    logic sticky_clear;
    assign sticky_clear = do_write && wr_mapped && wr_addr[7:0] == `OFS_STATUS
        && wr_strb[0] && wr_data[`STATUS_STICKY_BIT];
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            result <= `RST_WORD;
        else if (activate)
            result <= next_result;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            success_output <= 1'b0;
        else
            success_output <= activate && in_range;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            status <= `RST_STATUS;
        else
        begin
            if (activate)
            begin
                status.contact_level_bit <= 1'b1;
                status.condition_hi_bit <= !exact[65] && exact != '0;
                status.condition_lo_bit <= exact[65];
                status.range_error_flag <= !in_range;
                status.success <= in_range;
            end
            // Setting wins over a clear in the same cycle
            if (activate && !in_range)
                status.sticky_error_flag <= 1'b1;
            else if (sticky_clear)
                status.sticky_error_flag <= 1'b0;
        end
    end
    // ==========================================================
    // Event flags and interrupt
    arith_pkg::event_t events;
    arith_pkg::event_t event_enable;
    arith_pkg::event_t event_set;
    arith_pkg::event_t event_clr;
    assign event_set = '{range_event: activate && !in_range, done_event: activate};
    assign event_clr = (do_write && wr_mapped && wr_addr[7:0] == `OFS_EVENT_CLEAR
        && wr_strb[0]) ? arith_pkg::event_t'(wr_data[1:0]) : `RST_EVENT;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            events <= `RST_EVENT;
            event_enable <= `RST_EVENT;
            irq <= 1'b0;
        end
        else
        begin
            events <= event_set | (events & ~event_clr);
            if (do_write && wr_mapped && wr_addr[7:0] == `OFS_EVENT_ENABLE && wr_strb[0])
                event_enable <= arith_pkg::event_t'(wr_data[1:0]);
            irq <= |(events & event_enable);
        end
    end
    // ==========================================================
    // Read channel
    logic [31:0] rd_word;
    logic rd_mapped;
    assign rd_mapped = (s_axi_araddr[31:8] == 24'h00_0000) && (s_axi_araddr[1:0] == 2'h0)
        && (s_axi_araddr[7:0] <= `OFS_EVENT_ENABLE);
    always_comb
    begin
        rd_word = `RST_WORD;
        case (s_axi_araddr[7:0])
            `OFS_CONTROL: rd_word = {25'h000_0000, opcode, 4'h0};
            `OFS_FIRST: rd_word = first_operand;
            `OFS_SECOND: rd_word = second_operand;
            `OFS_RESULT: rd_word = result;
            `OFS_STATUS: rd_word = {26'h000_0000, status};
            `OFS_EVENT: rd_word = {30'h0000_0000, events};
            `OFS_EVENT_ENABLE: rd_word = {30'h0000_0000, event_enable};
            default: rd_word = `RST_WORD;
        endcase
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `RST_WORD;
            s_axi_rresp <= `RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mapped ? rd_word : `RST_WORD;
                s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
    // ==========================================================
    // Checks
    logic signed [31:0] product_ref;
    assign product_ref = $signed(first_operand[15:0]) * $signed(second_operand[15:0]);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_short_sum;
        activate && opcode == arith_pkg::OP_SHORT_SUM |=>
            result[15:0] == 16'($past(first_operand[15:0] + second_operand[15:0]));
    endproperty
    a_short_sum: assert property (p_short_sum) else $error("short sum wrong");
    property p_short_range;
        activate && is_short && opcode != arith_pkg::OP_SHORT_PRODUCT && !in_range |=>
            status.range_error_flag && status.sticky_error_flag && !success_output;
    endproperty
    a_short_range: assert property (p_short_range) else $error("short overflow");
    property p_long_sum;
        activate && opcode == arith_pkg::OP_LONG_SUM |=>
            result == 32'($past(first_operand + second_operand));
    endproperty
    a_long_sum: assert property (p_long_sum) else $error("long sum wrong");
    property p_short_diff;
        activate && opcode == arith_pkg::OP_SHORT_DIFF |=>
            result[15:0] == 16'($past(first_operand[15:0] - second_operand[15:0]));
    endproperty
    a_short_diff: assert property (p_short_diff) else $error("short diff wrong");
    property p_long_diff;
        activate && opcode == arith_pkg::OP_LONG_DIFF |=>
            result == 32'($past(first_operand - second_operand));
    endproperty
    a_long_diff: assert property (p_long_diff) else $error("long diff wrong");
    property p_short_prod;
        activate && opcode == arith_pkg::OP_SHORT_PRODUCT |=> result == $past(product_ref);
    endproperty
    a_short_prod: assert property (p_short_prod) else $error("short product wrong");
    property p_prod_range;
        activate && opcode == arith_pkg::OP_SHORT_PRODUCT && !in_range |=>
            !success_output && status.range_error_flag && result == $past(product_ref);
    endproperty
    a_prod_range: assert property (p_prod_range) else $error("product overflow");
    property p_long_prod;
        activate && opcode == arith_pkg::OP_LONG_PRODUCT |=>
            result == 32'($past(first_operand * second_operand));
    endproperty
    a_long_prod: assert property (p_long_prod) else $error("long product wrong");
    property p_contact;
        activate |=> status.contact_level_bit ##1 status.contact_level_bit;
    endproperty
    a_contact: assert property (p_contact) else $error("contact bit not set");
    property p_idle;
        !activate |=> !success_output;
    endproperty
    a_idle: assert property (p_idle) else $error("success without activate");
    property p_in_range;
        activate && in_range |=> !status.range_error_flag
            && status.sticky_error_flag == $past(status.sticky_error_flag);
    endproperty
    a_in_range: assert property (p_in_range) else $error("in-range flags wrong");
    property p_overflow;
        activate && !in_range |=> status.sticky_error_flag
            && {status.condition_hi_bit, status.condition_lo_bit} == ($past(exact[65])
            ? 2'h1 : 2'h2);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow flags wrong");
    property p_success;
        activate && in_range |=> success_output ##1 !success_output || $past(activate);
    endproperty
    a_success: assert property (p_success) else $error("success missing");
endmodule : integer_arith_unit

`default_nettype wire

// ===== verif/arith_sequencer.sv
// Sequencer model: AXI4-Lite master that feeds operands and commands
`timescale 1ns/1ps
`default_nettype none

module arith_sequencer
(
    input wire logic aclk,
    output logic [31:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [31:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready
);
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // Payload held until taken, then inverted so stale values never match
    task automatic wr(input logic [7:0] ofs, input logic [31:0] d, output logic [1:0] resp);
        resp = 2'h3;
        @(posedge aclk);
        awaddr <= {24'h00_0000, ofs};
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
            begin
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (wvalid && wready)
            begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
            if (bvalid && bready)
            begin
                resp = bresp;
                bready <= 1'b0;
            end
        end
        while (awvalid || wvalid || bready);
    endtask : wr

    task automatic rd(input logic [7:0] ofs);
        @(posedge aclk);
        araddr <= {24'h00_0000, ofs};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
            begin
                arvalid <= 1'b0;
                araddr <= ~araddr;
            end
            if (rvalid && rready)
                rready <= 1'b0;
        end
        while (arvalid || rready);
    endtask : rd
endmodule : arith_sequencer
`default_nettype wire

// ===== verif/tb_integer_arith_unit.sv
// Self-checking bench for the integer arithmetic unit
`timescale 1ns/1ps
`include "arith_defs.svh"
`default_nettype none

module tb_integer_arith_unit;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr, wdata, araddr, rdata, n_succ = '0, n_succ_exp = '0;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, success_output, irq;
    logic sticky = 1'b0;
    logic [5:0] last_st = '0;
    logic [33:0] exp_q[$];
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;

    integer_arith_unit DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .success_output(success_output), .irq(irq));

    arith_sequencer u_seq (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));

    always #5 aclk = ~aclk;

    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // Monitor: read answers, success pulses, hang limit
    always @(posedge aclk)
    begin
        cyc++;
        if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0)
            check({rresp, rdata}, exp_q.pop_front());
        if (success_output === 1'b1)
            n_succ <= n_succ + 32'h0000_0001;
        if (cyc == 5000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic exp_rd(input logic [7:0] ofs, input logic [33:0] exp);
        exp_q.push_back(exp);
        u_seq.rd(ofs);
    endtask : exp_rd

    // Exact result worked out wide, then range and condition derived from it
    task automatic run_op(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b);
        longint x, y, e;
        logic ov;
        logic [31:0] res;
        x = op[0] ? longint'($signed(a)) : longint'($signed(a[15:0]));
        y = op[0] ? longint'($signed(b)) : longint'($signed(b[15:0]));
        e = (op[2:1] == 2'h0) ? x + y : (op[2:1] == 2'h1) ? x - y : x * y;
        ov = op[0] ? (e != longint'($signed(e[31:0]))) : (e != longint'($signed(e[15:0])));
        res = (op[0] || op[2]) ? e[31:0] : {{16{e[15]}}, e[15:0]};
        sticky = sticky | ov;
        last_st = {~ov, 1'b1, sticky, ov, e > 0, e < 0};
        n_succ_exp = n_succ_exp + {31'h0000_0000, ~ov};
        u_seq.wr(`OFS_FIRST, a, r);
        u_seq.wr(`OFS_SECOND, b, r);
        u_seq.wr(`OFS_CONTROL, {25'h000_0000, op, 4'h1}, r);
        exp_rd(`OFS_RESULT, res);
        exp_rd(`OFS_STATUS, last_st);
    endtask : run_op

    // ==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(13));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        exp_rd(`OFS_CONTROL, 34'h0_0000_0000);
        exp_rd(`OFS_STATUS, 34'h0_0000_0000);
        run_op(3'h0, 32'habcd_7fff, 32'h0000_0001);
        run_op(3'h0, 32'h0000_8000, 32'h0000_ffff);
        run_op(3'h0, 32'h0000_0005, 32'h1234_fffb);
        run_op(3'h1, 32'h7fff_ffff, 32'h0000_0001);
        run_op(3'h2, 32'h0000_8000, 32'h0000_0001);
        run_op(3'h2, 32'h0000_0009, 32'h0000_0002);
        run_op(3'h3, 32'h8000_0000, 32'h0000_0001);
        run_op(3'h3, 32'h0000_0003, 32'h0000_0007);
        run_op(3'h4, 32'h0000_012c, 32'h0000_012c);
        run_op(3'h4, 32'h0000_ffff, 32'h0000_0002);
        run_op(3'h5, 32'h0001_0000, 32'h0001_0000);
        run_op(3'h5, 32'h0000_0007, 32'hffff_fffa);
        // Sticky flag cleared by status write; inactive and unknown-opcode commands leave status alone
        u_seq.wr(`OFS_STATUS, 32'h0000_0008, r);
        sticky = 1'b0;
        last_st[3] = 1'b0;
        exp_rd(`OFS_STATUS, last_st);
        u_seq.wr(`OFS_CONTROL, 32'h0000_0010, r);
        exp_rd(`OFS_STATUS, last_st);
        u_seq.wr(`OFS_CONTROL, 32'h0000_0061, r);
        exp_rd(`OFS_CONTROL, 34'h0_0000_0010);
        exp_rd(`OFS_STATUS, last_st);
        // Events, masking and the interrupt line
        u_seq.wr(`OFS_EVENT_CLEAR, 32'h0000_0003, r);
        run_op(3'h1, 32'h0000_0002, 32'h0000_0003);
        exp_rd(`OFS_EVENT, 34'h0_0000_0001);
        check(irq, 1'b0);
        u_seq.wr(`OFS_EVENT_ENABLE, 32'h0000_0001, r);
        repeat (3) @(posedge aclk);
        check(irq, 1'b1);
        u_seq.wr(`OFS_EVENT_CLEAR, 32'h0000_0001, r);
        repeat (3) @(posedge aclk);
        check(irq, 1'b0);
        u_seq.wr(`OFS_EVENT_ENABLE, 32'h0000_0002, r);
        run_op(3'h0, 32'h0000_7fff, 32'h0000_7fff);
        exp_rd(`OFS_EVENT, 34'h0_0000_0003);
        exp_rd(`OFS_EVENT_ENABLE, 34'h0_0000_0002);
        check(irq, 1'b1);
        // Unmapped place answers with an error
        exp_rd(8'h20, {2'h2, 32'h0000_0000});
        u_seq.wr(8'h20, 32'h0000_ffff, r);
        check(r, 2'h2);
        repeat (12) run_op(3'($urandom_range(5, 0)), $urandom, $urandom);
        repeat (4) @(posedge aclk);
        check(n_succ, n_succ_exp);
        check(exp_q.size(), 34'h0_0000_0000);
        report_and_stop();
    end
endmodule : tb_integer_arith_unit
`default_nettype wire
